// ==== rwc_map_regs.vh ====
// Register offsets, field positions, reset values and counts of the slice.
`ifndef RWC_MAP_REGS_VH
`define RWC_MAP_REGS_VH

// Byte offsets on the peripheral bus.
`define RWC_PPCR_OFF 10'h004
`define RWC_CLEAR_OFF 10'h0d0
`define RWC_STATUS_OFF 10'h0d4
`define RWC_UNLOCK_OFF 10'h058
`define RWC_RST_FLAGS_OFF 10'h180
`define RWC_WAKE_FLAGS_OFF 10'h184
`define RWC_WAKE_EN_OFF 10'h188
`define RWC_CONFIG_OFF 10'h3f8
`define RWC_VERSION_OFF 10'h3fc

// Unlock word layout: key in the top byte, target address in the low bits.
`define RWC_UNLOCK_KEY 8'haa
`define RWC_KEY_MSB 31
`define RWC_KEY_LSB 24
`define RWC_ADDR_MSB 9

// Status and clear registers: access error flag position.
`define RWC_ACC_ERR_BIT 31

// Peripheral power control: stored width and request-clock mask positions.
`define RWC_PPCR_W 9
`define RWC_PPCR_RESET 9'h000
`define RWC_TOUCH_MASK_BIT 3
`define RWC_COMP_MASK_BIT 4
`define RWC_CONV_MASK_BIT 5
`define RWC_ATMR_MASK_BIT 6
`define RWC_TWS0_MASK_BIT 7
`define RWC_TWS1_MASK_BIT 8

// Reset-cause flag positions.
`define RWC_RC_POR 0
`define RWC_RC_BROWNOUT 1
`define RWC_RC_PIN 2
`define RWC_RC_WATCHDOG 3
`define RWC_RC_SLEEP 6
`define RWC_RC_OCD 8
`define RWC_RC_JTAG 9
`define RWC_RC_ONEPIN 12

// Wake-cause flag positions for the sources that are not asynchronous.
`define RWC_WC_IRQ_CTRL 16
`define RWC_WC_ATMR 17

// Asynchronous wake-up enable width and reset value.
`define RWC_WAKE_EN_W 5
`define RWC_WAKE_EN_RESET 5'h00

// Read-only contents. The version value is arbitrary.
`define RWC_CONFIG_VAL 32'h0000_008f
`define RWC_VERSION_VAL 32'h0000_0123

// Edges after reset release before the synchronised cause pins are valid.
`define RWC_CAPTURE_EDGES 2'h2

`endif

// ==== rwc_sync.v ====
// Two-flop synchroniser for a vector of asynchronous pins.
`timescale 1ns/10ps
`default_nettype none

module rwc_sync #(
	parameter WIDTH = 8
) (
	input wire mclk_in, // Bus clock.
	input wire rst_n_in, // Asynchronous reset, active low.
	input wire [WIDTH-1:0] async_in, // Pins from another domain.
	output wire [WIDTH-1:0] sync_out // Synchronised copy.
);

	// First stage, read only by the second stage.
	reg [WIDTH-1:0] meta_q;
	// Second stage, safe for logic.
	reg [WIDTH-1:0] stable_q;

	genvar g;
	generate
		for (g = 0; g < WIDTH; g = g + 1) begin : g_bit
			// Each bit passes two flops before any logic sees it.
			always @(posedge mclk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					meta_q[g] <= 1'b0;
					stable_q[g] <= 1'b0;
				end else begin
					meta_q[g] <= async_in[g];
					stable_q[g] <= meta_q[g];
				end
			end
		end
	endgenerate

	assign sync_out = stable_q;

endmodule // rwc_sync

`default_nettype wire

// ==== rwc_core.v ====
// Power manager slice: locked clock masks, reset and wake cause, ids.
//
// How it works
// - One request-clock mask bit per listed unit.
// - Mask register writes need a preceding unlock.
// - Unlock: key 0xAA, address, then write as next access.
// - Locked write without unlock sets access error.
// - Reset-cause bit 12: one-pin debug reset.
// - Reset-cause bit 9: boundary-scan system reset.
// - Reset-cause bit 8: debug control reset strobe.
// - Reset-cause bit 6: wake from shutdown.
// - Reset-cause bit 3: watchdog timeout.
// - Reset-cause bit 2: external reset pin.
// - Reset-cause bit 1: brown-out.
// - Reset-cause bit 0: power-on or regulator undervoltage.
// - Wake-cause bits 0-4, 16, 17 per waking peripheral.
// - Wake-up enable register, read-write, resets zero.
// - Enable bits 0-4 gate sources; rest reserved.
// - Read-only configuration: event clock, buses D-A.
// - Read-only version, no behavioural effect.
`timescale 1ns/10ps
`default_nettype none
`include "rwc_map_regs.vh"

module rwc_core (
	input wire mclk_in, // Bus clock, 200 MHz.
	input wire rst_n_in, // Asynchronous system reset, active low.
	input wire pb_sel_in, // Peripheral bus access strobe.
	input wire pb_write_in, // High for write, low for read.
	input wire [9:0] pb_addr_in, // Byte address of the access.
	input wire [31:0] pb_wdata_in, // Write data.
	output reg [31:0] pb_rdata_out, // Read data, one cycle after.
	input wire [7:0] rst_cause_in, // Reset source levels from the pins.
	input wire [6:0] wake_req_in, // Wake request levels from peripherals.
	output wire touch_req_clk_mask_out, // Touch unit request clock on.
	output wire comparator_req_clk_mask_out, // Comparator clock on.
	output wire converter_req_clk_mask_out, // Converter clock on.
	output wire async_timer_req_clk_mask_out, // Async timer clock on.
	output wire two_wire_slave0_req_clk_mask_out, // Slave 0 clock on.
	output wire two_wire_slave1_req_clk_mask_out, // Slave 1 clock on.
	output wire [4:0] async_wake_enable_out, // Wake enables per source.
	output wire access_error_flag_out // Sticky access error.
);

	// Stored peripheral power control bits.
	reg [`RWC_PPCR_W-1:0] ppcr_q;
	// Unlock armed for exactly the next access.
	reg unlock_armed_q;
	// Address that the unlock opened.
	reg [`RWC_ADDR_MSB:0] unlock_addr_q;
	// Sticky access error.
	reg access_error_flag_q;
	// Reset-cause flags.
	reg [31:0] reset_source_flags_q;
	// Wake-cause flags.
	reg [31:0] wake_source_flags_q;
	// Asynchronous wake-up enables.
	reg [`RWC_WAKE_EN_W-1:0] async_wake_enable_q;
	// Counts edges after release until the cause pins are trustworthy.
	reg [1:0] capture_cnt_q;
	// High once the reset cause has been taken.
	reg capture_done_q;
	// Previous synchronised wake levels, for edge detection.
	reg [6:0] wake_prev_q;
	// Synchronised pins.
	wire [7:0] cause_sync;
	wire [6:0] wake_sync;
	// Bus decode terms.
	wire wr_en;
	wire ppcr_hit;
	wire ppcr_allowed;
	wire unlock_good;
	wire err_clear;
	wire [6:0] wake_rise;
	wire [6:0] wake_gated;

	// True when the access address equals a register offset.
	function hit;
		input [9:0] addr;
		input [9:0] off;
		begin
			hit = (addr == off);
		end
	endfunction

	// Priority pick of one reset source into the flag layout.
	function [31:0] cause_flags;
		input [7:0] src;
		begin
			cause_flags = 32'h0000_0000;
			if (src[0]) begin
				cause_flags[`RWC_RC_POR] = 1'b1;
			end else if (src[1]) begin
				cause_flags[`RWC_RC_BROWNOUT] = 1'b1;
			end else if (src[2]) begin
				cause_flags[`RWC_RC_PIN] = 1'b1;
			end else if (src[3]) begin
				cause_flags[`RWC_RC_WATCHDOG] = 1'b1;
			end else if (src[4]) begin
				cause_flags[`RWC_RC_SLEEP] = 1'b1;
			end else if (src[6]) begin
				cause_flags[`RWC_RC_JTAG] = 1'b1;
			end else if (src[5]) begin
				cause_flags[`RWC_RC_OCD] = 1'b1;
			end else if (src[7]) begin
				cause_flags[`RWC_RC_ONEPIN] = 1'b1;
			end
		end
	endfunction

	// Priority pick of one wake source into the flag layout.
	function [31:0] wake_flags;
		input [6:0] src;
		integer i;
		begin
			wake_flags = 32'h0000_0000;
			if (src[5]) begin
				wake_flags[`RWC_WC_IRQ_CTRL] = 1'b1;
			end else if (src[6]) begin
				wake_flags[`RWC_WC_ATMR] = 1'b1;
			end else begin
				for (i = 4; i >= 0; i = i - 1) begin
					if (src[i]) begin
						wake_flags = 32'h0000_0000;
						wake_flags[i] = 1'b1;
					end
				end
			end
		end
	endfunction

	// Cause pins arrive from the reset controller's domain.
	rwc_sync #(
		.WIDTH(8)
	) u_cause_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(rst_cause_in),
		.sync_out(cause_sync)
	);

	// Wake requests arrive from asynchronous peripherals.
	rwc_sync #(
		.WIDTH(7)
	) u_wake_sync (
		.mclk_in(mclk_in),
		.rst_n_in(rst_n_in),
		.async_in(wake_req_in),
		.sync_out(wake_sync)
	);

	assign wr_en = pb_sel_in & pb_write_in;
	assign ppcr_hit = wr_en & hit(pb_addr_in, `RWC_PPCR_OFF);
	assign ppcr_allowed = unlock_armed_q &
		(unlock_addr_q == pb_addr_in);
	assign unlock_good = wr_en & hit(pb_addr_in, `RWC_UNLOCK_OFF) &
		(pb_wdata_in[`RWC_KEY_MSB:`RWC_KEY_LSB] == `RWC_UNLOCK_KEY);
	assign err_clear = wr_en & hit(pb_addr_in, `RWC_CLEAR_OFF) &
		pb_wdata_in[`RWC_ACC_ERR_BIT];
	assign wake_rise = wake_sync & ~wake_prev_q;
	assign wake_gated = {wake_rise[6:5],
		wake_rise[4:0] & async_wake_enable_q};

	// Unlock lasts for one access only; any access spends it.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			unlock_armed_q <= 1'b0;
			unlock_addr_q <= 10'h000;
		end else if (pb_sel_in) begin
			unlock_armed_q <= unlock_good;
			if (unlock_good) begin
				unlock_addr_q <= pb_wdata_in[`RWC_ADDR_MSB:0];
			end
		end
	end

	// Mask register takes a write only right after a matching unlock.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ppcr_q <= `RWC_PPCR_RESET;
		end else if (ppcr_hit & ppcr_allowed) begin
			ppcr_q <= pb_wdata_in[`RWC_PPCR_W-1:0];
		end
	end

	// Error is sticky; a new error in the clear cycle wins.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			access_error_flag_q <= 1'b0;
		end else if (ppcr_hit & ~ppcr_allowed) begin
			access_error_flag_q <= 1'b1;
		end else if (err_clear) begin
			access_error_flag_q <= 1'b0;
		end
	end

	// Wake enables are plain read-write bits.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			async_wake_enable_q <= `RWC_WAKE_EN_RESET;
		end else if (wr_en & hit(pb_addr_in, `RWC_WAKE_EN_OFF)) begin
			async_wake_enable_q <= pb_wdata_in[`RWC_WAKE_EN_W-1:0];
		end
	end

	// Cause pins need two edges to settle, so capture waits for them.
	// The register clears under reset, so only the latest cause shows.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			capture_cnt_q <= 2'h0;
			capture_done_q <= 1'b0;
			reset_source_flags_q <= 32'h0000_0000;
		end else if (!capture_done_q) begin
			if (capture_cnt_q == `RWC_CAPTURE_EDGES) begin
				capture_done_q <= 1'b1;
				reset_source_flags_q <= cause_flags(cause_sync);
			end else begin
				capture_cnt_q <= capture_cnt_q + 2'h1;
			end
		end
	end

	// A new wake replaces whatever the last wake left behind.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wake_prev_q <= 7'h00;
			wake_source_flags_q <= 32'h0000_0000;
		end else begin
			wake_prev_q <= wake_sync;
			if (|wake_gated) begin
				wake_source_flags_q <= wake_flags(wake_gated);
			end
		end
	end

	// Read data is registered; cause and id registers ignore writes.
	always @(posedge mclk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			pb_rdata_out <= 32'h0000_0000;
		end else if (pb_sel_in & ~pb_write_in) begin
			case (pb_addr_in)
				`RWC_PPCR_OFF: begin
					pb_rdata_out <= {23'h00_0000, ppcr_q};
				end
				`RWC_STATUS_OFF: begin
					pb_rdata_out <= {access_error_flag_q, 31'h0000_0000};
				end
				`RWC_RST_FLAGS_OFF: begin
					pb_rdata_out <= reset_source_flags_q;
				end
				`RWC_WAKE_FLAGS_OFF: begin
					pb_rdata_out <= wake_source_flags_q;
				end
				`RWC_WAKE_EN_OFF: begin
					// Reserved bits read as zero.
					pb_rdata_out <= {27'h000_0000, async_wake_enable_q};
				end
				`RWC_CONFIG_OFF: begin
					pb_rdata_out <= `RWC_CONFIG_VAL;
				end
				`RWC_VERSION_OFF: begin
					pb_rdata_out <= `RWC_VERSION_VAL;
				end
				default: begin
					// Unmapped and write-only offsets read zero.
					pb_rdata_out <= 32'h0000_0000;
				end
			endcase
		end
	end

	assign touch_req_clk_mask_out = ppcr_q[`RWC_TOUCH_MASK_BIT];
	assign comparator_req_clk_mask_out = ppcr_q[`RWC_COMP_MASK_BIT];
	assign converter_req_clk_mask_out = ppcr_q[`RWC_CONV_MASK_BIT];
	assign async_timer_req_clk_mask_out = ppcr_q[`RWC_ATMR_MASK_BIT];
	assign two_wire_slave0_req_clk_mask_out = ppcr_q[`RWC_TWS0_MASK_BIT];
	assign two_wire_slave1_req_clk_mask_out = ppcr_q[`RWC_TWS1_MASK_BIT];
	assign async_wake_enable_out = async_wake_enable_q;
	assign access_error_flag_out = access_error_flag_q;

endmodule // rwc_core

`default_nettype wire

// ==== rwc_core_checker.sv ====
// Concurrent checks on the ports of the register slice.
`timescale 1ns/10ps
`default_nettype none
module rwc_core_checker (
	input wire logic mclk_in, // Bus clock.
	input wire logic rst_n_in, // Reset, active low.
	input wire logic pb_sel_in, // Access strobe.
	input wire logic pb_write_in, // Write select.
	input wire logic [9:0] pb_addr_in, // Byte address.
	input wire logic [31:0] pb_wdata_in, // Write data.
	input wire logic [31:0] pb_rdata_out, // Read data.
	input wire logic touch_req_clk_mask_out, // Mask bit 3.
	input wire logic comparator_req_clk_mask_out, // Mask bit 4.
	input wire logic converter_req_clk_mask_out, // Mask bit 5.
	input wire logic async_timer_req_clk_mask_out, // Mask bit 6.
	input wire logic two_wire_slave0_req_clk_mask_out, // Mask bit 7.
	input wire logic two_wire_slave1_req_clk_mask_out, // Mask bit 8.
	input wire logic [4:0] async_wake_enable_out, // Wake enables.
	input wire logic access_error_flag_out // Sticky error.
);
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!rst_n_in);
	wire wr = pb_sel_in && pb_write_in; // Any write.
	wire rd = pb_sel_in && !pb_write_in; // Any read.
	wire wmask = wr && pb_addr_in == 10'h004; // Write to the locked register.
	wire clr = wr && pb_addr_in == 10'h0d0 && pb_wdata_in[31]; // Error clear.
	wire unl = wr && pb_addr_in == 10'h058 && pb_wdata_in[31:24] == 8'haa &&
		pb_wdata_in[9:0] == 10'h004; // Good unlock for the mask register.
	wire [5:0] masks = {two_wire_slave1_req_clk_mask_out,
		two_wire_slave0_req_clk_mask_out, async_timer_req_clk_mask_out,
		converter_req_clk_mask_out, comparator_req_clk_mask_out,
		touch_req_clk_mask_out}; // Mask outputs in register order.
	logic armed_q; // An unlock waits; any other access spends it.
	always_ff @(posedge mclk_in or negedge rst_n_in)
		if (!rst_n_in)
			armed_q <= 1'b0;
		else if (pb_sel_in)
			armed_q <= unl;
	AST_UNLOCK_OPENS: assert property (wmask && armed_q |=>
		masks == $past(pb_wdata_in[8:3])) else $error("unlocked write lost");
	AST_LOCK_HOLDS: assert property (wmask && !armed_q |=>
		$stable(masks)) else $error("locked write took effect");
	AST_ERR_SETS: assert property (wmask && !armed_q |->
		##[1:2] access_error_flag_out) else $error("no access error");
	AST_ERR_STICKY: assert property (access_error_flag_out && !clr |=>
		access_error_flag_out) else $error("access error dropped");
	AST_ERR_CLEARS: assert property (clr |=>
		!access_error_flag_out) else $error("access error not cleared");
	AST_MASK_CAUSE: assert property (!$stable(masks) |->
		$past(wmask)) else $error("mask changed without a write");
	AST_WAKE_EN_WR: assert property (wr && pb_addr_in == 10'h188 |=>
		async_wake_enable_out == $past(pb_wdata_in[4:0]))
		else $error("wake enable not written");
	AST_WAKE_EN_RD: assert property (rd && pb_addr_in == 10'h188 |=>
		pb_rdata_out == {27'h0, $past(async_wake_enable_out)})
		else $error("wake enable readback wrong");
	AST_CONFIG_RD: assert property (rd && pb_addr_in == 10'h3f8 |=>
		pb_rdata_out == 32'h0000_008f) else $error("config readback wrong");
	AST_VERSION_RD: assert property (rd && pb_addr_in == 10'h3fc |=>
		pb_rdata_out == 32'h0000_0123) else $error("version readback wrong");
	AST_WAKE_ONEHOT: assert property (rd && pb_addr_in == 10'h184 |=>
		$onehot0(pb_rdata_out)) else $error("wake cause not one-hot");
	cover property (wmask && armed_q);
	cover property (wmask && !armed_q);
	cover property (rd && pb_addr_in == 10'h184);
endmodule // rwc_core_checker
`default_nettype wire

// ==== rwc_core_tb.sv ====
// Self-checking bench for the register slice.
`timescale 1ns/10ps
`default_nettype none
module rwc_core_tb;
	logic mclk_in = 0, rst_n_in = 0, pb_sel_in = 0, pb_write_in = 0;
	logic [9:0] pb_addr_in = 10'h000;
	logic [31:0] pb_wdata_in = 32'h0000_0000, pb_rdata_out;
	logic [7:0] rst_cause_in = 8'h01; // Power-on cause by default.
	logic [6:0] wake_req_in = 7'h00;
	logic [4:0] async_wake_enable_out;
	logic m0, m1, m2, m3, m4, m5, access_error_flag_out;
	wire [5:0] masks = {m5, m4, m3, m2, m1, m0};
	int err_count = 0, compares = 0, cycles = 0;
	always #2.5 mclk_in = ~mclk_in;
	rwc_core u_dut (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
		.pb_sel_in(pb_sel_in), .pb_write_in(pb_write_in),
		.pb_addr_in(pb_addr_in), .pb_wdata_in(pb_wdata_in),
		.pb_rdata_out(pb_rdata_out), .rst_cause_in(rst_cause_in),
		.wake_req_in(wake_req_in), .touch_req_clk_mask_out(m0),
		.comparator_req_clk_mask_out(m1), .converter_req_clk_mask_out(m2),
		.async_timer_req_clk_mask_out(m3),
		.two_wire_slave0_req_clk_mask_out(m4),
		.two_wire_slave1_req_clk_mask_out(m5),
		.async_wake_enable_out(async_wake_enable_out),
		.access_error_flag_out(access_error_flag_out));
	// Compares and counts; four-state equality so unknowns fail.
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus access, entered and left at a rising edge.
	task automatic acc(input logic w, input logic [9:0] a,
		input logic [31:0] d);
		pb_sel_in <= 1'b1;
		pb_write_in <= w;
		pb_addr_in <= a;
		pb_wdata_in <= d;
		@(posedge mclk_in);
	endtask
	task automatic idle;
		pb_sel_in <= 1'b0;
		@(posedge mclk_in);
	endtask
	// Two idle edges let a late status update land before checking.
	task automatic wr(input logic [9:0] a, input logic [31:0] d);
		acc(1'b1, a, d);
		idle;
		idle;
	endtask
	task automatic rdv(input logic [9:0] a, input logic [31:0] exp);
		acc(1'b0, a, 32'h0000_0000);
		pb_sel_in <= 1'b0;
		#1;
		chk(pb_rdata_out, exp);
		@(posedge mclk_in);
	endtask
	task automatic do_reset;
		rst_n_in <= 1'b0;
		repeat (4) @(posedge mclk_in);
		rst_n_in <= 1'b1;
		repeat (4) @(posedge mclk_in);
	endtask
	// Each reset source in turn; the last one always replaces the rest.
	task automatic t_cause;
		int pos[8] = '{0, 1, 2, 3, 6, 8, 9, 12};
		for (int i = 7; i >= 0; i--) begin
			rst_cause_in <= 8'(1 << i);
			do_reset;
			rdv(10'h180, 32'h0000_0001 << pos[i]);
		end
		wr(10'h180, 32'hffff_ffff);
		rdv(10'h180, 32'h0000_0001);
		$display("test cause done");
	endtask
	// Locked writes refused, unlock opens exactly one write.
	task automatic t_lock;
		wr(10'h004, 32'h0000_01f8);
		chk(masks, 6'h00);
		rdv(10'h0d4, 32'h8000_0000);
		wr(10'h0d0, 32'h8000_0000);
		chk(access_error_flag_out, 1'b0);
		acc(1'b1, 10'h058, 32'haa00_0004);
		acc(1'b1, 10'h004, 32'h0000_01f8);
		idle;
		chk(masks, 6'h3f);
		rdv(10'h004, 32'h0000_01f8);
		wr(10'h058, 32'haa00_0004);
		rdv(10'h188, 32'h0000_0000);
		wr(10'h004, 32'h0000_0000);
		chk({access_error_flag_out, masks}, 7'h7f);
		wr(10'h058, 32'h5500_0004);
		wr(10'h004, 32'h0000_0000);
		chk(masks, 6'h3f);
		wr(10'h058, 32'haa00_0004);
		wr(10'h004, 32'h0000_00a8);
		chk(masks, 6'h15);
		$display("test lock done");
	endtask
	// Enable register, reserved bits and read-only identity words.
	task automatic t_regs;
		wr(10'h188, 32'hffff_ffff);
		chk(async_wake_enable_out, 5'h1f);
		rdv(10'h188, 32'h0000_001f);
		wr(10'h3f8, 32'h0000_0000);
		wr(10'h3fc, 32'h0000_0000);
		rdv(10'h3f8, 32'h0000_008f);
		rdv(10'h3fc, 32'h0000_0123);
		$display("test regs done");
	endtask
	// Every wake source, then a gated one that must leave no trace.
	task automatic t_wake;
		int bitpos[7] = '{0, 1, 2, 3, 4, 16, 17};
		for (int i = 0; i < 7; i++) begin
			wake_req_in <= 7'(1 << i);
			repeat (6) @(posedge mclk_in);
			wake_req_in <= 7'h00;
			repeat (4) @(posedge mclk_in);
			rdv(10'h184, 32'h0000_0001 << bitpos[i]);
		end
		wr(10'h188, 32'h0000_0000);
		wake_req_in <= 7'h01;
		repeat (6) @(posedge mclk_in);
		wake_req_in <= 7'h00;
		wr(10'h184, 32'h0000_0001);
		rdv(10'h184, 32'h0002_0000);
		$display("test wake done");
	endtask
	task automatic print_verdict;
		$display("comparisons %0d mismatches %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Hang guard well above the few hundred cycles the tests need.
	always @(posedge mclk_in) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			print_verdict;
		end
	end
	initial begin
		do_reset;
		t_cause;
		t_lock;
		t_regs;
		t_wake;
		print_verdict;
	end
endmodule // rwc_core_tb
bind rwc_core rwc_core_checker u_chk (.mclk_in(mclk_in),
	.rst_n_in(rst_n_in), .pb_sel_in(pb_sel_in), .pb_write_in(pb_write_in),
	.pb_addr_in(pb_addr_in), .pb_wdata_in(pb_wdata_in),
	.pb_rdata_out(pb_rdata_out),
	.touch_req_clk_mask_out(touch_req_clk_mask_out),
	.comparator_req_clk_mask_out(comparator_req_clk_mask_out),
	.converter_req_clk_mask_out(converter_req_clk_mask_out),
	.async_timer_req_clk_mask_out(async_timer_req_clk_mask_out),
	.two_wire_slave0_req_clk_mask_out(two_wire_slave0_req_clk_mask_out),
	.two_wire_slave1_req_clk_mask_out(two_wire_slave1_req_clk_mask_out),
	.async_wake_enable_out(async_wake_enable_out),
	.access_error_flag_out(access_error_flag_out));
`default_nettype wire
